//--- aesb_dma_port.v
// One-word DMA master port: holds a request until the RAM acknowledges
`timescale 1ns/1ps
module aesb_dma_port (
    input  wire        clk,
    input  wire        reset,
    input  wire        go,
    input  wire        go_we,
    input  wire [31:0] go_addr,
    input  wire [31:0] go_wdata,
    output wire        busy,
    output reg         done_r,
    output reg  [31:0] rdata_r,
    output reg         dma_req_r,
    output reg         dma_we_r,
    output reg  [31:0] dma_addr_r,
    output reg  [31:0] dma_wdata_r,
    input  wire [31:0] dma_rdata,
    input  wire        dma_ack
);
    assign busy = dma_req_r;

    // Request stays up until ack; ack ends it and pulses done
    always @(posedge clk) begin
        if (reset) begin
            dma_req_r   <= 1'b0;
            dma_we_r    <= 1'b0;
            dma_addr_r  <= 32'h0;
            dma_wdata_r <= 32'h0;
            done_r      <= 1'b0;
            rdata_r     <= 32'h0;
        end else begin
            done_r <= 1'b0;
            if (dma_req_r && dma_ack) begin
                dma_req_r <= 1'b0;
                dma_we_r  <= 1'b0;
                done_r    <= 1'b1;
                rdata_r   <= dma_rdata;
            end else if (go && !dma_req_r) begin
                dma_req_r   <= 1'b1;
                dma_we_r    <= go_we;
                dma_addr_r  <= go_addr;
                dma_wdata_r <= go_wdata;
            end
        end
    end
endmodule // aesb_dma_port

//--- aesb_engine.v
// Block encryption engine: registers, DMA sequencing, shared core control
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "aesb_map.vh"

module aesb_engine (
    input  wire         clk,
    input  wire         reset,
    input  wire [11:0]  reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [31:0]  reg_rdata_r,
    output reg          irq_r,
    output wire         dma_req,
    output wire         dma_we,
    output wire [31:0]  dma_addr,
    output wire [31:0]  dma_wdata,
    input  wire [31:0]  dma_rdata,
    input  wire         dma_ack,
    input  wire         core_busy,
    input  wire         core_preempt,
    output reg          core_start_r,
    output wire [127:0] core_key,
    output wire [127:0] core_text,
    input  wire [127:0] core_result,
    input  wire         core_done,
    output reg          engine_busy_r
);
    // One-hot states
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_FETCH = 6'h02;
    localparam [5:0] ST_LOAD  = 6'h04;
    localparam [5:0] ST_CRYPT = 6'h08;
    localparam [5:0] ST_STORE = 6'h10;
    localparam [5:0] ST_WRITE = 6'h20;

    reg  [5:0]   state_r;
    reg  [5:0]   state_nxt;
    reg  [3:0]   idx_r;
    reg  [3:0]   idx_nxt;
    reg          phase_r;
    reg          phase_nxt;
    reg  [255:0] stream_r;
    reg  [255:0] stream_nxt;
    reg  [31:0]  ptr_r;
    reg  [1:0]   ien_r;
    reg          done_ev_r;
    reg          abort_ev_r;
    reg          set_done;
    reg          set_abort;
    reg          core_start_nxt;
    reg          dma_go;
    reg          dma_go_we;
    reg  [31:0]  dma_go_addr;
    reg          ram_we;
    reg  [3:0]   ram_waddr;
    reg  [31:0]  ram_wdata;
    reg  [3:0]   ram_raddr;
    wire [31:0]  ram_rdata;
    wire         dma_busy;
    wire         dma_done;
    wire [31:0]  dma_word;

    // Register strobes
    wire wr_start = reg_wr && (reg_addr == `AESB_OFF_START) && reg_wdata[0];
    wire wr_stop  = reg_wr && (reg_addr == `AESB_OFF_STOP) && reg_wdata[0];
    wire running  = !state_r[0];

    // Byte address of word idx of a structure field
    function [31:0] field_addr;
        input [31:0] base;
        input [31:0] off;
        input [3:0]  idx;
        begin
            field_addr = base + off + {26'h0, idx, 2'b00};
        end
    endfunction

    assign core_key  = stream_r[255:128];
    assign core_text = stream_r[127:0];

    aesb_word_ram #(
        .DEPTH (12),
        .AW    (4),
        .DW    (32)
    ) u_ram (
        .clk       (clk),
        .wr_en     (ram_we),
        .wr_addr   (ram_waddr),
        .wr_data   (ram_wdata),
        .rd_addr   (ram_raddr),
        .rd_data_r (ram_rdata)
    );

    aesb_dma_port u_dma (
        .clk         (clk),
        .reset       (reset),
        .go          (dma_go),
        .go_we       (dma_go_we),
        .go_addr     (dma_go_addr),
        .go_wdata    (ram_rdata),
        .busy        (dma_busy),
        .done_r      (dma_done),
        .rdata_r     (dma_word),
        .dma_req_r   (dma_req),
        .dma_we_r    (dma_we),
        .dma_addr_r  (dma_addr),
        .dma_wdata_r (dma_wdata),
        .dma_rdata   (dma_rdata),
        .dma_ack     (dma_ack)
    );

    // Sequencer next state
    always @* begin
        state_nxt      = state_r;
        idx_nxt        = idx_r;
        phase_nxt      = phase_r;
        stream_nxt     = stream_r;
        set_done       = 1'b0;
        set_abort      = 1'b0;
        core_start_nxt = 1'b0;
        dma_go         = 1'b0;
        dma_go_we      = 1'b0;
        dma_go_addr    = 32'h0;
        ram_we         = 1'b0;
        ram_waddr      = idx_r;
        ram_wdata      = dma_word;
        ram_raddr      = idx_r;
        case (state_r)
            ST_IDLE: begin
                if (wr_start) begin
                    if (core_busy) begin
                        set_abort = 1'b1;
                    end else begin
                        state_nxt = ST_FETCH;
                        idx_nxt   = 4'h0;
                        phase_nxt = 1'b0;
                    end
                end
            end
            ST_FETCH: begin
                // Key words 0..3 then text words 4..7 into staging
                if (!phase_r && !dma_busy) begin
                    dma_go      = 1'b1;
                    dma_go_addr = field_addr(ptr_r, `AESB_KEY_OFF,
                                             idx_r);
                    phase_nxt   = 1'b1;
                end else if (phase_r && dma_done) begin
                    ram_we    = 1'b1;
                    phase_nxt = 1'b0;
                    idx_nxt   = idx_r + 4'h1;
                    if (idx_r == 4'h7) begin
                        state_nxt = ST_LOAD;
                        idx_nxt   = 4'h0;
                    end
                end
            end
            ST_LOAD: begin
                // Read staging into key/text; data lags address a cycle
                if (phase_r) begin
                    stream_nxt = {stream_r[223:0], ram_rdata};
                end
                phase_nxt = 1'b1;
                idx_nxt   = idx_r + 4'h1;
                if (idx_r == 4'h8) begin
                    state_nxt      = ST_CRYPT;
                    phase_nxt      = 1'b0;
                    core_start_nxt = 1'b1;
                end
            end
            ST_CRYPT: begin
                if (core_done) begin
                    stream_nxt = {stream_r[255:128], core_result};
                    state_nxt  = ST_STORE;
                    idx_nxt    = 4'h0;
                end
            end
            ST_STORE: begin
                // Result words into staging slots 8..11
                ram_we     = 1'b1;
                ram_waddr  = `AESB_RES_BASE + idx_r;
                ram_wdata  = stream_r[127:96];
                stream_nxt = {stream_r[255:128], stream_r[95:0], 32'h0};
                idx_nxt    = idx_r + 4'h1;
                if (idx_r == 4'h3) begin
                    state_nxt = ST_WRITE;
                    idx_nxt   = 4'h0;
                    phase_nxt = 1'b0;
                end
            end
            ST_WRITE: begin
                ram_raddr = `AESB_RES_BASE + idx_r;
                if (!phase_r && !dma_busy) begin
                    phase_nxt = 1'b1;
                end else if (phase_r && !dma_busy && !dma_done) begin
                    dma_go      = 1'b1;
                    dma_go_we   = 1'b1;
                    dma_go_addr = field_addr(ptr_r, `AESB_CIPHER_OFF,
                                             idx_r);
                end else if (phase_r && dma_done) begin
                    phase_nxt = 1'b0;
                    idx_nxt   = idx_r + 4'h1;
                    if (idx_r == 4'h3) begin
                        state_nxt = ST_IDLE;
                        set_done  = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Stop task or core conflict ends any running job
        if (running && (wr_stop || core_preempt)) begin
            state_nxt      = ST_IDLE;
            set_abort      = 1'b1;
            set_done       = 1'b0;
            core_start_nxt = 1'b0;
            dma_go         = 1'b0;
            ram_we         = 1'b0;
        end
    end

    // Sequencer registers
    always @(posedge clk) begin
        if (reset) begin
            state_r       <= ST_IDLE;
            idx_r         <= 4'h0;
            phase_r       <= 1'b0;
            stream_r      <= 256'h0;
            core_start_r  <= 1'b0;
            engine_busy_r <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            idx_r         <= idx_nxt;
            phase_r       <= phase_nxt;
            stream_r      <= stream_nxt;
            core_start_r  <= core_start_nxt;
            engine_busy_r <= !state_nxt[0];
        end
    end

    // Software registers; a hardware set wins over a same-cycle write
    always @(posedge clk) begin
        if (reset) begin
            ptr_r      <= `AESB_PTR_RESET;
            ien_r      <= `AESB_IEN_RESET;
            done_ev_r  <= 1'b0;
            abort_ev_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `AESB_OFF_PTR) begin
                ptr_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `AESB_OFF_IEN_SET) begin
                ien_r <= ien_r | reg_wdata[1:0];
            end else if (reg_wr && reg_addr == `AESB_OFF_IEN_CLR) begin
                ien_r <= ien_r & ~reg_wdata[1:0];
            end
            if (set_done) begin
                done_ev_r <= 1'b1;
            end else if (reg_wr && reg_addr == `AESB_OFF_DONE_EV) begin
                done_ev_r <= reg_wdata[0];
            end
            if (set_abort) begin
                abort_ev_r <= 1'b1;
            end else if (reg_wr && reg_addr == `AESB_OFF_ABORT_EV) begin
                abort_ev_r <= reg_wdata[0];
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata_r <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata_r <= 32'h0;
        end else if (reg_addr == `AESB_OFF_DONE_EV) begin
            reg_rdata_r <= {31'h0, done_ev_r};
        end else if (reg_addr == `AESB_OFF_ABORT_EV) begin
            reg_rdata_r <= {31'h0, abort_ev_r};
        end else if (reg_addr == `AESB_OFF_IEN_SET) begin
            reg_rdata_r <= {30'h0, ien_r};
        end else if (reg_addr == `AESB_OFF_IEN_CLR) begin
            reg_rdata_r <= {30'h0, ien_r};
        end else if (reg_addr == `AESB_OFF_PTR) begin
            reg_rdata_r <= ptr_r;
        end else begin
            reg_rdata_r <= 32'h0;
        end
    end

    // Level interrupt from enabled events
    always @(posedge clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (done_ev_r & ien_r[`AESB_BIT_DONE]) |
                     (abort_ev_r & ien_r[`AESB_BIT_ABORT]);
        end
    end
endmodule // aesb_engine

//--- aesb_engine_sva.sv
// Checker for the block encryption engine ports
`timescale 1ns/1ps
`include "aesb_map.vh"
module aesb_engine_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_r,
    input wire logic        irq_r,
    input wire logic        dma_req,
    input wire logic        dma_we,
    input wire logic [31:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    input wire logic        dma_ack,
    input wire logic        core_busy,
    input wire logic        core_preempt,
    input wire logic        core_start_r,
    input wire logic        engine_busy_r
);
    reg [1:0]  en_r;
    reg [31:0] ptr_r;
    wire start_w = reg_wr && reg_addr == `AESB_OFF_START && reg_wdata[0];
    wire stop_w  = reg_wr && reg_addr == `AESB_OFF_STOP && reg_wdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow of the software-written enables and pointer
    always @(posedge clk) begin
        if (reset) begin
            en_r  <= 2'h0;
            ptr_r <= 32'h0;
        end else if (reg_wr) begin
            if (reg_addr == `AESB_OFF_IEN_SET) en_r <= en_r | reg_wdata[1:0];
            if (reg_addr == `AESB_OFF_IEN_CLR) en_r <= en_r & ~reg_wdata[1:0];
            if (reg_addr == `AESB_OFF_PTR) ptr_r <= reg_wdata;
        end
    end
    property p_start_go;
        start_w && !core_busy && !engine_busy_r |=> engine_busy_r;
    endproperty
    a_start_go: assert property (p_start_go) else $error("start ignored");
    property p_start_busy;
        start_w && core_busy && !engine_busy_r |=> !engine_busy_r;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("ran on busy core");
    property p_stop;
        engine_busy_r && stop_w |-> ##[1:2] !engine_busy_r;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_preempt;
        engine_busy_r && core_preempt |-> ##[1:2] !engine_busy_r;
    endproperty
    a_preempt: assert property (p_preempt) else $error("conflict kept job");
    property p_rd_idle;
        !reg_rd |=> reg_rdata_r == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data stray");
    property p_rd_en;
        reg_rd && (reg_addr == `AESB_OFF_IEN_SET || reg_addr == `AESB_OFF_IEN_CLR)
            |=> reg_rdata_r == {30'h0, $past(en_r)};
    endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable readback");
    property p_rd_ptr;
        reg_rd && reg_addr == `AESB_OFF_PTR |=> reg_rdata_r == $past(ptr_r);
    endproperty
    a_rd_ptr: assert property (p_rd_ptr) else $error("pointer readback");
    property p_mask;
        en_r == 2'h0 |=> !irq_r;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_dma_hold;
        dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_we)
            && $stable(dma_wdata);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma request moved");
    property p_core_pulse;
        core_start_r |-> engine_busy_r ##1 !core_start_r;
    endproperty
    a_core_pulse: assert property (p_core_pulse) else $error("core start bad");
    c_start: cover property (start_w && !core_busy);
    c_stop: cover property (stop_w && engine_busy_r);
    c_preempt: cover property (core_preempt && engine_busy_r);
    c_irq: cover property (irq_r);
endmodule // aesb_engine_sva
bind aesb_engine aesb_engine_sva u_sva (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .irq_r(irq_r),
    .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack), .core_busy(core_busy),
    .core_preempt(core_preempt), .core_start_r(core_start_r),
    .engine_busy_r(engine_busy_r));

//--- aesb_far_model.sv
// Far-side model: data RAM behind the DMA port and a stand-in AES core
`timescale 1ns/1ps
module aesb_far_model (
    input  wire         clk,
    input  wire         reset,
    input  wire         slow,
    input  wire         dma_req,
    input  wire         dma_we,
    input  wire [31:0]  dma_addr,
    input  wire [31:0]  dma_wdata,
    output reg  [31:0]  dma_rdata,
    output reg          dma_ack,
    input  wire         core_start_r,
    input  wire [127:0] core_key,
    input  wire [127:0] core_text,
    output wire [127:0] core_result,
    output reg          core_done
);
    reg [31:0]  mem [0:63];
    reg [3:0]   wait_r;
    reg [4:0]   cnt_r;
    reg [127:0] res_r;
    integer     i;
    // Known fill so key and text words differ
    initial begin
        dma_rdata = 32'h0;
        for (i = 0; i < 64; i++) mem[i] = 32'h9e37_79b9 * (i + 1);
    end
    // One ack per request; idle read data inverts so stale bits never match
    always @(posedge clk) begin
        if (reset) begin
            dma_ack <= 1'b0;
            wait_r  <= 4'h0;
        end else if (dma_req && !dma_ack && wait_r >= (slow ? 4'h3 : 4'h0)) begin
            dma_ack <= 1'b1;
            wait_r  <= 4'h0;
            if (dma_we) mem[dma_addr[7:2]] <= dma_wdata;
            else dma_rdata <= mem[dma_addr[7:2]];
        end else begin
            dma_ack   <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_req && !dma_ack) wait_r <= wait_r + 4'h1;
        end
    end
    // Core stand-in: result is key xor text after a fixed run time
    always @(posedge clk) begin
        if (reset) begin
            core_done <= 1'b0;
            cnt_r     <= 5'h0;
        end else if (core_start_r) begin
            cnt_r     <= slow ? 5'h14 : 5'h4;
            res_r     <= core_key ^ core_text;
            core_done <= 1'b0;
        end else begin
            core_done <= (cnt_r == 5'h1);
            if (cnt_r != 5'h0) cnt_r <= cnt_r - 5'h1;
        end
    end
    assign core_result = core_done ? res_r : ~res_r;
endmodule // aesb_far_model

//--- aesb_map.vh
// Register offsets, field positions and structure layout of the engine
`ifndef AESB_MAP_VH
`define AESB_MAP_VH

// Register offsets, byte addresses
`define AESB_OFF_START      12'h000
`define AESB_OFF_STOP       12'h004
`define AESB_OFF_DONE_EV    12'h100
`define AESB_OFF_ABORT_EV   12'h104
`define AESB_OFF_IEN_SET    12'h304
`define AESB_OFF_IEN_CLR    12'h308
`define AESB_OFF_PTR        12'h504

// Event and enable bit positions
`define AESB_BIT_DONE       0
`define AESB_BIT_ABORT      1

// Reset values
`define AESB_PTR_RESET      32'h0000_0000
`define AESB_IEN_RESET      2'h0

// Structure layout in RAM, byte offsets
`define AESB_KEY_OFF        32'h0000_0000
`define AESB_TEXT_OFF       32'h0000_0010
`define AESB_CIPHER_OFF     32'h0000_0020

// Staging memory index of the first result word
`define AESB_RES_BASE       4'h8

`endif

//--- aesb_word_ram.v
// Staging memory for key, cleartext and ciphertext words
`timescale 1ns/1ps
module aesb_word_ram #(
    parameter DEPTH = 12,
    parameter AW    = 4,
    parameter DW    = 32
) (
    input  wire          clk,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_r
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // Write port; registered read one cycle after the address
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_r <= mem[rd_addr];
    end
endmodule // aesb_word_ram

//--- tb_top.sv
// Testbench for the block encryption engine
`timescale 1ns/1ps
`include "aesb_map.vh"
module tb_top;
    typedef struct packed {
        logic        do_w;
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] exp;
    } aesb_row_t;
    localparam aesb_row_t ROWS [0:9] = '{
        '{1'b0, 12'h0, 32'h0, `AESB_OFF_PTR, 32'h0},
        '{1'b0, 12'h0, 32'h0, `AESB_OFF_DONE_EV, 32'h0},
        '{1'b0, 12'h0, 32'h0, `AESB_OFF_ABORT_EV, 32'h0},
        '{1'b0, 12'h0, 32'h0, `AESB_OFF_IEN_SET, 32'h0},
        '{1'b1, `AESB_OFF_PTR, 32'h40, `AESB_OFF_PTR, 32'h40},
        '{1'b1, `AESB_OFF_IEN_SET, 32'h3, `AESB_OFF_IEN_CLR, 32'h3},
        '{1'b1, `AESB_OFF_IEN_CLR, 32'h1, `AESB_OFF_IEN_SET, 32'h2},
        '{1'b1, `AESB_OFF_IEN_SET, 32'h0, `AESB_OFF_IEN_SET, 32'h2},
        '{1'b1, 12'h200, 32'hffff_ffff, 12'h200, 32'h0},
        '{1'b1, `AESB_OFF_IEN_CLR, 32'h2, `AESB_OFF_IEN_CLR, 32'h0}};
    reg          clk, reset, reg_wr, reg_rd, core_busy, core_preempt, slow;
    reg  [11:0]  reg_addr;
    reg  [31:0]  reg_wdata;
    wire [31:0]  reg_rdata_r, dma_addr, dma_wdata, dma_rdata;
    wire         irq_r, dma_req, dma_we, dma_ack, core_start_r, core_done;
    wire         engine_busy_r;
    wire [127:0] core_key, core_text, core_result;
    integer      bad_count = 0;
    integer      num_checks = 0;
    integer      n, j;
    aesb_engine u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .irq_r(irq_r), .dma_req(dma_req),
        .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_rdata(dma_rdata), .dma_ack(dma_ack), .core_busy(core_busy),
        .core_preempt(core_preempt), .core_start_r(core_start_r),
        .core_key(core_key), .core_text(core_text),
        .core_result(core_result), .core_done(core_done),
        .engine_busy_r(engine_busy_r));
    aesb_far_model u_far (.clk(clk), .reset(reset), .slow(slow),
        .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
        .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_ack(dma_ack),
        .core_start_r(core_start_r), .core_key(core_key),
        .core_text(core_text), .core_result(core_result),
        .core_done(core_done));
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            num_checks++;
            if (got !== exp) begin
                bad_count++;
                $display("wrong value %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr    <= 1'b0;
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] exp, input string nm);
        begin
            @(posedge clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd   <= 1'b0;
            #1;
            chk(nm, exp, reg_rdata_r);
        end
    endtask
    task wait_idle;
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (engine_busy_r !== 1'b0 && n < 600) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("engine idle", 32'h0, {31'h0, engine_busy_r});
        end
    endtask
    task irqchk(input exp);
        begin
            repeat (2) @(posedge clk);
            #1;
            chk("irq", {31'h0, exp}, {31'h0, irq_r});
        end
    endtask
    // Watchdog against a hung handshake
    initial begin
        #100000;
        bad_count++;
        end_sim;
    end
    // Main sequence
    initial begin
        {reg_wr, reg_rd, core_busy, core_preempt, slow} = 5'h0;
        reg_addr  = 12'h0;
        reg_wdata = 32'h0;
        reset     = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        foreach (ROWS[k]) begin
            if (ROWS[k].do_w) wr(ROWS[k].wa, ROWS[k].wd);
            rdchk(ROWS[k].ra, ROWS[k].exp, "row read");
        end
        $display("end of test: registers");
        wr(`AESB_OFF_STOP, 32'h1);
        rdchk(`AESB_OFF_ABORT_EV, 32'h0, "idle stop");
        $display("end of test: idle stop");
        slow <= 1'b1;
        wr(`AESB_OFF_IEN_SET, 32'h1);
        wr(`AESB_OFF_START, 32'h1);
        wait_idle;
        rdchk(`AESB_OFF_DONE_EV, 32'h1, "done event");
        rdchk(`AESB_OFF_ABORT_EV, 32'h0, "abort event");
        for (j = 0; j < 4; j++)
            chk("cipher", u_far.mem[16+j] ^ u_far.mem[20+j], u_far.mem[24+j]);
        irqchk(1'b1);
        wr(`AESB_OFF_DONE_EV, 32'h0);
        irqchk(1'b0);
        $display("end of test: full job");
        slow <= 1'b0;
        @(posedge clk);
        core_busy <= 1'b1;
        wr(`AESB_OFF_START, 32'h1);
        core_busy <= 1'b0;
        #1;
        chk("busy refused", 32'h0, {31'h0, engine_busy_r});
        rdchk(`AESB_OFF_ABORT_EV, 32'h1, "busy abort");
        wr(`AESB_OFF_ABORT_EV, 32'h0);
        $display("end of test: core busy");
        wr(`AESB_OFF_START, 32'h1);
        repeat (6) @(posedge clk);
        wr(`AESB_OFF_STOP, 32'h1);
        wait_idle;
        rdchk(`AESB_OFF_ABORT_EV, 32'h1, "stop abort");
        rdchk(`AESB_OFF_DONE_EV, 32'h0, "stop done");
        wr(`AESB_OFF_ABORT_EV, 32'h0);
        $display("end of test: stop");
        wr(`AESB_OFF_IEN_SET, 32'h2);
        wr(`AESB_OFF_START, 32'h1);
        n = 0;
        while (core_start_r !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        core_preempt <= 1'b1;
        @(posedge clk);
        core_preempt <= 1'b0;
        wait_idle;
        rdchk(`AESB_OFF_ABORT_EV, 32'h1, "conflict abort");
        irqchk(1'b1);
        wr(`AESB_OFF_IEN_CLR, 32'h2);
        irqchk(1'b0);
        $display("end of test: conflict");
        wr(`AESB_OFF_IEN_SET, 32'h3);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdchk(`AESB_OFF_PTR, 32'h0, "reset pointer");
        rdchk(`AESB_OFF_IEN_SET, 32'h0, "reset enables");
        rdchk(`AESB_OFF_ABORT_EV, 32'h0, "reset abort");
        $display("end of test: second reset");
        end_sim;
    end
endmodule // tb_top
